// *** rtl/mac8_slice.sv ***
// Top of the 8-bit serial-by-parallel multiplier/accumulator slice
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "mac8_defs.svh"

// Behaviour
// - Multiplier built from four 2-bit carry-save cells
// - Cell forms 0, 1X, 2X or 3X
// - Add multiple, shifted product and saved carry
// - Low cell bits drive sum; add-control selects
// - Codes 0-3 load Y from accumulator half
// - Codes 4,5 load Y, clear accumulator
// - Code 6 loads Y, holds accumulator
// - Code 7 iterates last and reloads
// - Codes 8,9 put accumulator half on bus
// - Codes A,B copy accumulator half into X
// - Code C changes no data registers unless it follows D or F
// - Accumulator shift runs one clock late
// - E loads X; F loads X and iterates
// - Overflow stored only after C or 7
// - Two slices give 32-bit product in sixteen
// - One slice: 16-bit product, eight iterations
// - X latch holds multiplicand during iteration
// - Active-low enable gates bus drivers
module mac8_slice (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic [3:0] i_instruction_code,
  input wire logic [7:0] i_bus_data,
  output logic [7:0] o_bus_data,
  output logic o_bus_oe,
  input wire logic i_out_en_n,
  output logic o_overflow_flag,
  input wire logic [1:0] i_sum_in,
  output logic [1:0] o_sum_out,
  input wire logic [1:0] i_y_serial_in,
  output logic [1:0] o_y_serial_out,
  input wire logic i_x_link_in,
  output logic o_x_link_out,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);

  // ============================================================
  // Declarations
  mac8_pkg::op_t op;
  logic [1:0] cfg;
  logic msb_byte;
  logic lsb_add;
  logic [7:0] x_reg;
  logic [7:0] x_latch;
  logic [7:0] y_reg;
  logic [15:0] acc;
  logic acc_carry;
  logic shift_q;
  logic first_shift;
  logic overflow_flag_en_q;
  logic overflow_store;
  logic clear_pending;
  logic last_iter;
  logic iterate;
  logic [7:0] acc_half;
  logic [7:0] load_src_y;
  logic [7:0] load_src_x;
  logic [7:0] pp_flat;
  logic [9:0] pp_chain;
  logic [8:0] x_ext;
  logic [1:0] add_b;
  logic add_cin;
  logic [2:0] add_sum;
  logic [1:0] low_sum;
  logic add_overflow;
  logic apb_setup;
  logic apb_write;
  logic [31:0] next_prdata;
  logic next_pslverr;

  assign msb_byte = cfg[`CFG_MSB_BYTE_BIT];
  assign lsb_add = cfg[`CFG_LSB_ADD_BIT];

  // ============================================================
  // Instruction decode
  // Code is sampled straight from the sequencer on the rising edge
  mac8_decode u_decode (
    .i_instruction_code(i_instruction_code),
    .o_op(op)
  );

  // An idle code right after code D or F completes the last digit
  assign iterate = op.iter | (op.idle & last_iter);

  // Track whether the previous code was a mid-product iteration
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      last_iter <= 1'b0;
    end else begin
      last_iter <= op.iter & ~op.clr_m;
    end
  end

  // Multiplier clear is deferred so code 7 can finish the old product
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      clear_pending <= `CLEAR_PENDING_RESET;
    end else if (op.clr_m) begin
      clear_pending <= 1'b1;
    end else if (iterate) begin
      clear_pending <= 1'b0;
    end
  end

  // ============================================================
  // Source selection
  assign acc_half = op.hi_half ? acc[15:8] : acc[7:0];
  assign load_src_y = op.use_bus ? i_bus_data : acc_half;
  assign load_src_x = op.use_bus ? i_bus_data : acc_half;

  // X register loads from bus or accumulator half
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      x_reg <= 8'h00;
    end else if (op.x_load) begin
      x_reg <= load_src_x;
    end
  end

  // X latch feeds the cells; only transfer codes touch it
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      x_latch <= 8'h00;
      o_x_link_out <= 1'b0;
    end else if (op.xfer_x) begin
      x_latch <= x_reg;
      o_x_link_out <= x_reg[7];
    end
  end

  // Y register: parallel load wins over the 2-bit shift
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      y_reg <= 8'h00;
    end else if (op.y_load) begin
      y_reg <= load_src_y;
    end else if (iterate) begin
      y_reg <= {msb_byte ? {2{y_reg[7]}} : i_y_serial_in, y_reg[7:2]};
    end
  end

  assign o_y_serial_out = y_reg[1:0];

  // ============================================================
  // Multiplier cells
  assign x_ext = {x_latch, i_x_link_in};
  assign pp_chain = {i_sum_in, pp_flat};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_cell
      mac8_cell #(
        .TOP_CELL(g == 3)
      ) u_cell (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_iterate(iterate),
        .i_discard(clear_pending),
        .i_msb(msb_byte),
        .i_y_digit(y_reg[1:0]),
        .i_x_pair(x_ext[2*g+2:2*g+1]),
        .i_x_prev(x_ext[2*g]),
        .i_pp_above(pp_chain[2*g+3:2*g+2]),
        .o_pp(pp_flat[2*g+1:2*g])
      );
    end
  endgenerate

  assign o_sum_out = pp_flat[1:0];

  // ============================================================
  // Summing adder and accumulator
  // Add-control low passes the accumulator through unchanged
  always_comb begin
    add_b = lsb_add ? pp_flat[1:0] : 2'h0;
    add_cin = first_shift ? 1'b0 : acc_carry;
    add_sum = {1'b0, acc[1:0]} + {1'b0, add_b} + {2'h0, add_cin};
    low_sum = {1'b0, acc[0]} + {1'b0, add_b[0]} + {1'b0, add_cin};
    add_overflow = low_sum[1] ^ add_sum[2];
  end

  // Shift command is registered, so shifting lags the iteration
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      shift_q <= 1'b0;
      first_shift <= 1'b1;
      overflow_flag_en_q <= 1'b0;
    end else begin
      shift_q <= iterate;
      first_shift <= iterate & clear_pending;
      overflow_flag_en_q <= op.overflow_flag_arm;
    end
  end

  // Accumulator: clear beats the delayed shift
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      acc <= 16'h0000;
      acc_carry <= 1'b0;
    end else if (op.clr_acc) begin
      acc <= 16'h0000;
      acc_carry <= 1'b0;
    end else if (shift_q) begin
      acc <= {add_sum[1:0], acc[15:2]};
      acc_carry <= add_sum[2];
    end
  end

  // Overflow is caught on the final shift after an idle or code 7
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      overflow_store <= 1'b0;
    end else if (overflow_flag_en_q && shift_q) begin
      overflow_store <= add_overflow;
    end
  end

  // ============================================================
  // Pin outputs
  // Codes 0-3 and 8-B drive the flag; read codes drive the selected half
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_overflow_flag <= 1'b0;
    end else if (op.overflow_flag_read) begin
      o_overflow_flag <= overflow_store;
    end
  end

  // Bus driver enable follows the read code gated by the enable pin
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_bus_data <= 8'h00;
      o_bus_oe <= 1'b0;
    end else begin
      o_bus_oe <= op.bus_read & ~i_out_en_n;
      if (op.bus_read) begin
        o_bus_data <= acc_half;
      end
    end
  end

  // ============================================================
  // APB slave
  assign apb_setup = i_psel & ~i_penable;
  assign apb_write = i_psel & i_penable & o_pready & i_pwrite;

  // Read data and error are prepared in the setup cycle
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    unique case (i_paddr)
      `REG_CONFIG: next_prdata = {30'h0, cfg};
      `REG_STATUS: begin
        next_prdata[`ST_OVERFLOW_BIT] = overflow_store;
        next_prdata[`ST_CLEAR_PENDING_BIT] = clear_pending;
        next_prdata[`ST_ITERATING_BIT] = last_iter;
      end
      `REG_ACC: next_prdata = {16'h0000, acc};
      `REG_OPERANDS: next_prdata = {8'h00, x_latch, x_reg, y_reg};
      default: next_pslverr = 1'b1;
    endcase
    if (i_pwrite) begin
      next_prdata = 32'h0000_0000;
      next_pslverr = (i_paddr != `REG_CONFIG) && (i_paddr != `REG_STATUS)
                   && (i_paddr != `REG_ACC) && (i_paddr != `REG_OPERANDS);
    end
  end

  // Zero-wait answer: ready rises in the access phase
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= apb_setup;
      if (apb_setup) begin
        o_prdata <= next_prdata;
        o_pslverr <= next_pslverr;
      end else begin
        o_pslverr <= 1'b0;
      end
    end
  end

  // Configuration: slice position and summing-adder control
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      cfg <= `CFG_RESET;
    end else if (apb_write && (i_paddr == `REG_CONFIG)) begin
      cfg <= i_pwdata[1:0];
    end
  end

endmodule : mac8_slice
`default_nettype wire

// *** rtl/mac8_defs.svh ***
// Constants for the serial-by-parallel multiplier/accumulator slice
`ifndef MAC8_DEFS_SVH
`define MAC8_DEFS_SVH

// ============================================================
// Instruction codes
`define IC_LOW_ACC_TO_MULTIPLIER_REG_CLEAR 4'h0
`define IC_HIGH_ACC_TO_MULTIPLIER_REG_CLEAR 4'h1
`define IC_LOW_ACC_TO_MULTIPLIER_REG_HOLD 4'h2
`define IC_HIGH_ACC_TO_MULTIPLIER_REG_HOLD 4'h3
`define IC_BUS_LOAD_MULTIPLIER_CLEAR_ACC_A 4'h4
`define IC_BUS_LOAD_MULTIPLIER_CLEAR_ACC_B 4'h5
`define IC_BUS_LOAD_MULTIPLIER_HOLD_ACC 4'h6
`define IC_BUS_LOAD_MULTIPLIER_AND_ITERATE 4'h7
`define IC_READ_LOW_ACC_HALF 4'h8
`define IC_READ_HIGH_ACC_HALF 4'h9
`define IC_LOW_ACC_TO_MULTIPLICAND 4'ha
`define IC_HIGH_ACC_TO_MULTIPLICAND 4'hb
`define IC_IDLE_CODE 4'hc
`define IC_ITERATE_CODE 4'hd
`define IC_LOAD_MULTIPLICAND_HOLD_ACC 4'he
`define IC_LOAD_MULTIPLICAND_AND_ITERATE 4'hf

// ============================================================
// Register offsets (byte addresses)
`define REG_CONFIG 8'h00
`define REG_STATUS 8'h04
`define REG_ACC 8'h08
`define REG_OPERANDS 8'h0c

// ============================================================
// Field positions
`define CFG_MSB_BYTE_BIT 0
`define CFG_LSB_ADD_BIT 1
`define ST_OVERFLOW_BIT 0
`define ST_CLEAR_PENDING_BIT 1
`define ST_ITERATING_BIT 2

// ============================================================
// Reset values
`define CFG_RESET 2'h3
`define CLEAR_PENDING_RESET 1'b1

`endif

// *** rtl/mac8_pkg.sv ***
// Types shared by the multiplier/accumulator slice
package mac8_pkg;

  // ============================================================
  // Decoded micro-operation carried from decoder to datapath
  typedef struct packed {
    logic clr_m;
    logic clr_acc;
    logic xfer_x;
    logic y_load;
    logic x_load;
    logic use_bus;
    logic hi_half;
    logic iter;
    logic bus_read;
    logic overflow_flag_read;
    logic overflow_flag_arm;
    logic idle;
  } op_t;

endpackage : mac8_pkg

// *** rtl/mac8_cell.sv ***
// One 2-bit carry-save multiplier cell
`timescale 1ns/10ps
`default_nettype none
`include "mac8_defs.svh"

module mac8_cell #(
  parameter bit TOP_CELL = 1'b0
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_iterate,
  input wire logic i_discard,
  input wire logic i_msb,
  input wire logic [1:0] i_y_digit,
  input wire logic [1:0] i_x_pair,
  input wire logic i_x_prev,
  input wire logic [1:0] i_pp_above,
  output logic [1:0] o_pp
);

  // ============================================================
  // Storage: two carry-save and two partial-product flip-flops
  logic carry_a;
  logic carry_b;
  logic signed_mode;
  logic c_a;
  logic c_b;
  logic [1:0] above;
  logic [1:0] hi;
  logic [2:0] multiple;
  logic [2:0] next_sum;
  logic [3:0] top_sum;

  // Sign handling only on the top cell of the most significant slice
  assign signed_mode = TOP_CELL && i_msb;

  // ============================================================
  // Adders: multiple of X, then partial product plus saved carry
  always_comb begin
    c_a = i_discard ? 1'b0 : carry_a;
    c_b = i_discard ? 1'b0 : carry_b;
    above = i_discard ? 2'h0 : i_pp_above;
    hi = {c_b, c_a};
    // 0, 1X, 2X or 3X from X and 2X slices
    multiple = (i_y_digit[0] ? {1'b0, i_x_pair} : 3'h0)
             + (i_y_digit[1] ? {1'b0, i_x_pair[0], i_x_prev} : 3'h0)
             + {2'h0, c_a};
    next_sum = {1'b0, above} + {1'b0, multiple[1:0]} + {2'h0, c_b};
    // Top cell keeps a signed high part that re-enters itself after the shift
    top_sum = {{2{hi[1]}}, hi}
            + (i_y_digit[0] ? {{2{i_x_pair[1]}}, i_x_pair} : 4'h0)
            + (i_y_digit[1] ? {i_x_pair[1], i_x_pair, i_x_prev} : 4'h0);
  end

  // Carry and partial product update on each iteration
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_pp <= 2'h0;
      carry_a <= 1'b0;
      carry_b <= 1'b0;
    end else if (i_iterate) begin
      if (signed_mode) begin
        o_pp <= top_sum[1:0];
        carry_a <= top_sum[2];
        carry_b <= top_sum[3];
      end else begin
        o_pp <= next_sum[1:0];
        carry_a <= multiple[2];
        carry_b <= next_sum[2];
      end
    end
  end

endmodule : mac8_cell
`default_nettype wire

// *** rtl/mac8_decode.sv ***
// Instruction decoder for the multiplier/accumulator slice
`timescale 1ns/10ps
`default_nettype none
`include "mac8_defs.svh"

module mac8_decode (
  input wire logic [3:0] i_instruction_code,
  output mac8_pkg::op_t o_op
);

  // ============================================================
  // Sixteen codes onto fifteen micro-operations (4 and 5 decode alike)
  always_comb begin
    o_op = '0;
    unique case (i_instruction_code)
      `IC_LOW_ACC_TO_MULTIPLIER_REG_CLEAR, `IC_HIGH_ACC_TO_MULTIPLIER_REG_CLEAR,
      `IC_LOW_ACC_TO_MULTIPLIER_REG_HOLD, `IC_HIGH_ACC_TO_MULTIPLIER_REG_HOLD: begin
        o_op.y_load = 1'b1;
        o_op.xfer_x = 1'b1;
        o_op.clr_m = 1'b1;
        o_op.overflow_flag_read = 1'b1;
        o_op.hi_half = i_instruction_code[0];
        o_op.clr_acc = ~i_instruction_code[1];
      end
      `IC_BUS_LOAD_MULTIPLIER_CLEAR_ACC_A, `IC_BUS_LOAD_MULTIPLIER_CLEAR_ACC_B: begin
        o_op.y_load = 1'b1;
        o_op.use_bus = 1'b1;
        o_op.xfer_x = 1'b1;
        o_op.clr_m = 1'b1;
        o_op.clr_acc = 1'b1;
      end
      `IC_BUS_LOAD_MULTIPLIER_HOLD_ACC: begin
        o_op.y_load = 1'b1;
        o_op.use_bus = 1'b1;
        o_op.xfer_x = 1'b1;
        o_op.clr_m = 1'b1;
      end
      `IC_BUS_LOAD_MULTIPLIER_AND_ITERATE: begin
        o_op.y_load = 1'b1;
        o_op.use_bus = 1'b1;
        o_op.xfer_x = 1'b1;
        o_op.clr_m = 1'b1;
        o_op.iter = 1'b1;
        o_op.overflow_flag_arm = 1'b1;
      end
      `IC_READ_LOW_ACC_HALF, `IC_READ_HIGH_ACC_HALF: begin
        o_op.bus_read = 1'b1;
        o_op.overflow_flag_read = 1'b1;
        o_op.hi_half = i_instruction_code[0];
      end
      `IC_LOW_ACC_TO_MULTIPLICAND, `IC_HIGH_ACC_TO_MULTIPLICAND: begin
        o_op.x_load = 1'b1;
        o_op.overflow_flag_read = 1'b1;
        o_op.hi_half = i_instruction_code[0];
      end
      `IC_IDLE_CODE: begin
        o_op.idle = 1'b1;
        o_op.overflow_flag_arm = 1'b1;
      end
      `IC_ITERATE_CODE: begin
        o_op.iter = 1'b1;
      end
      `IC_LOAD_MULTIPLICAND_HOLD_ACC: begin
        o_op.x_load = 1'b1;
        o_op.use_bus = 1'b1;
      end
      `IC_LOAD_MULTIPLICAND_AND_ITERATE: begin
        o_op.x_load = 1'b1;
        o_op.use_bus = 1'b1;
        o_op.iter = 1'b1;
      end
    endcase
  end

endmodule : mac8_decode
`default_nettype wire

// *** verification/mac8_slice_props.sv ***
// Checker for the multiplier/accumulator slice ports
`timescale 1ns/10ps
`default_nettype none
`include "mac8_defs.svh"

module mac8_slice_props (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic [3:0] i_instruction_code,
  input wire logic [7:0] i_bus_data,
  input wire logic [7:0] o_bus_data,
  input wire logic o_bus_oe,
  input wire logic i_out_en_n,
  input wire logic o_overflow_flag,
  input wire logic [1:0] o_y_serial_out,
  input wire logic o_x_link_out,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  logic rd_code;
  logic overflow_flag_code;
  logic setup;
  logic mapped;

  // ============================================================
  // Decoded antecedents
  assign rd_code = i_instruction_code inside {`IC_READ_LOW_ACC_HALF, `IC_READ_HIGH_ACC_HALF};
  assign overflow_flag_code = i_instruction_code inside {[4'h0:4'h3], [4'h8:4'hb]};
  assign setup = i_psel && !i_penable;
  assign mapped = i_paddr inside {`REG_CONFIG, `REG_STATUS, `REG_ACC, `REG_OPERANDS};

  // ============================================================
  // Instruction port
  a_oe_on_read: assert property (rd_code && !i_out_en_n |=> o_bus_oe)
    else $error("bus drive missing after read code");
  a_oe_off_else: assert property (!(rd_code && !i_out_en_n) |=> !o_bus_oe)
    else $error("bus driven without enabled read");
  a_bus_data_held: assert property (!rd_code |=> $stable(o_bus_data))
    else $error("bus data changed without read code");
  a_overflow_flag_flag_held: assert property (!overflow_flag_code |=> $stable(o_overflow_flag))
    else $error("overflow flag changed on wrong code");
  a_y_from_bus: assert property (i_instruction_code inside {4'h4, 4'h5, 4'h6}
    |=> o_y_serial_out == $past(i_bus_data[1:0]))
    else $error("multiplier digit not loaded from bus");
  a_idle_no_change: assert property ((i_instruction_code == `IC_IDLE_CODE) [*2]
    |=> $stable(o_y_serial_out) && $stable(o_x_link_out))
    else $error("idle code changed data registers");

  // ============================================================
  // Register bus
  a_pready_answer: assert property (setup |=> o_pready)
    else $error("no zero-wait answer");
  a_pready_single: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (setup && !mapped |=> o_pslverr && o_prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (setup && mapped |=> !o_pslverr)
    else $error("mapped access refused");

  // Main scenarios
  c_read_drive: cover property (rd_code && !i_out_en_n);
  c_chain: cover property (i_instruction_code == `IC_BUS_LOAD_MULTIPLIER_AND_ITERATE);
  c_refused: cover property (o_pslverr);
endmodule : mac8_slice_props

bind mac8_slice mac8_slice_props i_props (
  .i_core_clk(i_core_clk), .i_srst(i_srst), .i_instruction_code(i_instruction_code),
  .i_bus_data(i_bus_data), .o_bus_data(o_bus_data), .o_bus_oe(o_bus_oe), .i_out_en_n(i_out_en_n),
  .o_overflow_flag(o_overflow_flag), .o_y_serial_out(o_y_serial_out), .o_x_link_out(o_x_link_out),
  .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr)
);
`default_nettype wire

// *** verification/mac8_seq_model.sv ***
// Microprogram sequencer model driving codes and bus
`timescale 1ns/10ps
`default_nettype none
`include "mac8_defs.svh"

module mac8_seq_model (
  input wire logic i_core_clk,
  output logic [3:0] o_code,
  output logic [7:0] o_bus,
  output logic o_oe_n
);
  // Idle with drivers released at time zero
  initial begin
    o_code = `IC_IDLE_CODE;
    o_bus = 8'h00;
    o_oe_n = 1'b1;
  end

  // One code per clock; bus toggles when no load wants it
  task step(input logic [3:0] c, input logic [7:0] d, input logic oe_n);
    @(posedge i_core_clk);
    o_code <= c;
    o_oe_n <= oe_n;
    o_bus <= (c inside {[4'h4:4'h7], 4'he, 4'hf}) ? d : ~o_bus;
  endtask : step

  // Signed 8x8 product: load X, load Y, seven iterations, idle ends it
  task mul(input logic [7:0] x, input logic [7:0] y, input logic [3:0] yc);
    step(`IC_LOAD_MULTIPLICAND_HOLD_ACC, x, 1'b1);
    step(yc, y, 1'b1);
    repeat (7) step(`IC_ITERATE_CODE, 8'h00, 1'b1);
    step(`IC_IDLE_CODE, 8'h00, 1'b1);
    step(`IC_IDLE_CODE, 8'h00, 1'b1);
  endtask : mul
endmodule : mac8_seq_model
`default_nettype wire

// *** verification/mac8_slice_tb_top.sv ***
// Testbench for the slice through its sequencer model and APB
`timescale 1ns/10ps
`default_nettype none
`include "mac8_defs.svh"

module mac8_slice_tb_top;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] code;
  logic [7:0] bus;
  logic oe_n;
  logic [7:0] bus_out;
  logic bus_oe;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic overflow_flag;
  logic [31:0] rd;
  logic er;
  logic [15:0] acc;
  logic [7:0] xs[4] = '{8'h03, 8'hf9, 8'h7f, 8'h80};
  logic [7:0] ys[4] = '{8'h05, 8'h09, 8'h80, 8'h80};
  logic [3:0] mv[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'ha, 4'hb};
  int bad_count = 0;
  int samples_checked = 0;

  always #2 i_core_clk = ~i_core_clk;

  mac8_seq_model i_seq (.i_core_clk(i_core_clk), .o_code(code), .o_bus(bus), .o_oe_n(oe_n));

  mac8_slice i_dut (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .i_instruction_code(code), .i_bus_data(bus),
    .o_bus_data(bus_out), .o_bus_oe(bus_oe), .i_out_en_n(oe_n), .o_overflow_flag(overflow_flag),
    .i_sum_in(2'h0), .o_sum_out(), .i_y_serial_in(2'h0), .o_y_serial_out(),
    .i_x_link_in(1'b0), .o_x_link_out(), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr)
  );

  // ============================================================
  // Helpers
  function automatic logic [15:0] prod(input logic [7:0] x, input logic [7:0] y);
    return {{8{x[7]}}, x} * {{8{y[7]}}, y};
  endfunction : prod

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task tally_and_finish();
    $display("Checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // APB transfer, held until ready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_core_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("MISMATCH t=%0t no ready", $time);
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk

  // Read an accumulator half onto the bus and check the one-cycle drive
  task rd_half(input logic hi, input logic [7:0] e, input logic off_n);
    i_seq.step({3'b100, hi}, 8'h00, off_n);
    i_seq.step(`IC_IDLE_CODE, 8'h00, 1'b1);
    #1;
    check(32'(bus_out), 32'(e));
    check(32'(bus_oe), 32'(!off_n));
    i_seq.step(`IC_IDLE_CODE, 8'h00, 1'b1);
    #1;
    check(32'(bus_oe), 32'h0);
  endtask : rd_half

  // ============================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge i_core_clk);
    i_srst <= 1'b0;
    rdchk(`REG_CONFIG, 32'h3);
    apb(1'b0, `REG_STATUS, 32'h0);
    check(rd & 32'h2, 32'h2);
    rdchk(`REG_ACC, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check(32'(er), 32'h1);
    check(rd, 32'h0);
    apb(1'b1, `REG_CONFIG, 32'h0);
    rdchk(`REG_CONFIG, 32'h0);
    apb(1'b1, `REG_CONFIG, 32'h3);
    apb(1'b1, `REG_ACC, 32'hffff);
    rdchk(`REG_ACC, 32'h0);
    $display("Test registers done");
    for (int k = 0; k < 4; k++) begin
      i_seq.mul(xs[k], ys[k], k[0] ? 4'h5 : 4'h4);
      acc = prod(xs[k], ys[k]);
      rdchk(`REG_ACC, {16'h0, acc});
      rd_half(1'b1, acc[15:8], 1'b0);
      rd_half(1'b0, acc[7:0], 1'b0);
    end
    $display("Test products done");
    i_seq.mul(8'h11, 8'hf0, 4'h6);
    acc = acc + prod(8'h11, 8'hf0);
    rdchk(`REG_ACC, {16'h0, acc});
    rd_half(1'b1, acc[15:8], 1'b1);
    repeat (5) i_seq.step(`IC_IDLE_CODE, 8'h00, 1'b1);
    rdchk(`REG_ACC, {16'h0, acc});
    $display("Test accumulate done");
    i_seq.step(4'he, 8'h06, 1'b1);
    i_seq.step(4'h4, 8'hfd, 1'b1);
    repeat (6) i_seq.step(4'hd, 8'h00, 1'b1);
    i_seq.step(4'hf, 8'h0b, 1'b1);
    i_seq.step(4'h7, 8'h07, 1'b1);
    repeat (7) i_seq.step(4'hd, 8'h00, 1'b1);
    repeat (2) i_seq.step(4'hc, 8'h00, 1'b1);
    rdchk(`REG_ACC, {16'h0, prod(8'h06, 8'hfd) + prod(8'h0b, 8'h07)});
    $display("Test chain done");
    foreach (mv[k]) begin
      i_seq.mul(8'h35, 8'hd3, 4'h4);
      acc = prod(8'h35, 8'hd3);
      i_seq.step(mv[k], 8'h00, 1'b1);
      i_seq.step(`IC_IDLE_CODE, 8'h00, 1'b1);
      apb(1'b0, `REG_OPERANDS, 32'h0);
      check(32'(mv[k][3] ? rd[15:8] : rd[7:0]), 32'(mv[k][0] ? acc[15:8] : acc[7:0]));
      rdchk(`REG_ACC, (mv[k][3] | mv[k][1]) ? {16'h0, acc} : 32'h0);
    end
    $display("Test data moves done");
    // Two products of +16384 accumulate past the signed 16-bit range
    i_seq.mul(8'h80, 8'h80, 4'h4);
    i_seq.mul(8'h80, 8'h80, 4'h6);
    rd_half(1'b0, 8'h00, 1'b0);
    check(32'(overflow_flag), 32'h1);
    apb(1'b0, `REG_STATUS, 32'h0);
    check(rd & 32'h1, 32'h1);
    i_seq.mul(8'h03, 8'h05, 4'h4);
    rd_half(1'b0, 8'h0f, 1'b0);
    check(32'(overflow_flag), 32'h0);
    $display("Test overflow done");
    tally_and_finish();
  end

  // Watchdog against a hung run
  initial begin
    #100000;
    bad_count++;
    $display("MISMATCH t=%0t watchdog", $time);
    tally_and_finish();
  end
endmodule : mac8_slice_tb_top
`default_nettype wire
